// ### hw/cve_regs.svh
// Purpose: offsets, field positions, reset values and timing counts of the encoder core
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef CVE_REGS_SVH
`define CVE_REGS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CVE_OFF_ID2      8'h00
`define CVE_OFF_ID1      8'h01
`define CVE_OFF_ID0      8'h02
`define CVE_OFF_REV      8'h03
`define CVE_OFF_GCR      8'h04
`define CVE_OFF_VOCR     8'h05
`define CVE_OFF_FREQ2    8'h09
`define CVE_OFF_FREQ1    8'h0a
`define CVE_OFF_FREQ0    8'h0b
`define CVE_OFF_GPPCTL   8'h20
`define CVE_OFF_GPPRD    8'h21
`define CVE_OFF_GPPWR    8'h22
`define CVE_OFF_GPSCTL   8'hff
// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CVE_BIT_CHROMA_WIDE_BAND_SEL    5
`define CVE_BIT_GENLKEN  5
`define CVE_BIT_TIMING_SOURCE_SELECT    0
`define CVE_RST_GCR      8'h00
`define CVE_RST_VOCR     8'h00
`define CVE_RST_FREQ     24'h87c1f1
`define CVE_RST_GPPCTL   8'hff
`define CVE_RST_GPPWR    8'h00
`define CVE_RST_GPSCTL   8'h00
`define CVE_I2C_ADDR_HI  5'h03
// ----------------------------------------------------------------
// core clock and reset figures, then timing counts in 27 MHz ticks and lines
// ----------------------------------------------------------------
`define CVE_CLK_MHZ      20
`define CVE_RST_MIN_NS   200
`define CVE_RST_MIN_CYC  ((`CVE_RST_MIN_NS * `CVE_CLK_MHZ + 999) / 1000)
`define CVE_HTOT_525     11'h6b4
`define CVE_HTOT_625     11'h6c0
`define CVE_LINES_525    10'h20d
`define CVE_LINES_625    10'h271
`define CVE_F2_525       10'h107
`define CVE_F2_625       10'h139
`define CVE_BL_525_A     10'h00a
`define CVE_BL_525_B     10'h107
`define CVE_BL_525_C     10'h111
`define CVE_BL_525_D     10'h20d
`define CVE_BL_625_A     10'h006
`define CVE_BL_625_B     10'h136
`define CVE_BL_625_C     10'h13f
`define CVE_BL_625_D     10'h26f
`define CVE_SYNC_W       11'h07f
`define CVE_BST_ST       11'h08f
`define CVE_BST_9CYC     11'h044
`define CVE_BST_10CYC    11'h03d
`define CVE_ACT_ST       11'h100
`define CVE_ACT_END      11'h6a0
`define CVE_VS_N         10'h003
`endif

// ### hw/cve_pkg.sv
// Purpose: types shared by the encoder core
// Assumes: nothing
// Notes:   all state of the top but the reset release flops and the pixel fifo is one packed struct
package cve_pkg;
	typedef enum logic [6:0] {
		I2C_IDLE = 7'h01,
		I2C_ADDR = 7'h02,
		I2C_AACK = 7'h04,
		I2C_WRB  = 7'h08,
		I2C_WACK = 7'h10,
		I2C_RDB  = 7'h20,
		I2C_RACK = 7'h40
	} cve_i2c_e;
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} cve_pix_s;
	typedef struct packed {
		logic scl_s1, scl_s2, scl_q, sda_s1, sda_s2, sda_q;
		logic pck_s1, pck_s2, pck_q, ref_s1, ref_s2, ref_q;
		logic [1:0] sa_s1, sa_s2;
		logic [7:0] pd_s1, pd_s2, gp_s1, gp_s2;
		cve_i2c_e ist;
		logic [7:0] sh, ptr;
		logic [3:0] bitc;
		logic rw, first, ack_ok, sda_oe;
		logic [7:0] gcr, vocr, gppctl, gppwr, gpsctl;
		logic [23:0] freq, acc;
		logic half;
		logic [1:0] dph;
		logic [7:0] b1, b2, b3, y_l, cr_l, cb_l, cb_p, cr_p;
		logic f_l, h_l;
		logic [10:0] hcnt;
		logic [9:0] line;
		logic [2:0] fld;
		logic [7:0] luma, chroma, comp, gpo, gpoe;
		logic csync_n, burst, hs, vs, fifo_rdy;
	} cve_state_s;
endpackage : cve_pkg

// ### hw/cve_core.sv
// Purpose: digital core of a composite and s-video encoder with its i2c register port
// Assumes: core_clk 20 MHz; pixel clock, pixel data and pins synchronised on entry
// Notes:   cve_fifo buffers demultiplexed pixels between input and output timing
// Notes on behaviour
// - pixel bytes arrive as luma, cr, luma, cb and are split in that order
// - slave mode takes line and field timing from embedded timing codes
// - output samples each 27 MHz tick; chroma pair shared by two lumas
// - master mode generates all sync internally, ignoring stream codes
// - horizontal and vertical sync outputs driven for the host
// - eight pixel inputs sampled on pixel clock, bit 0 least significant
// - pixel clock divided by two for output pixel processing
// - eight-bit bidirectional general purpose port, direction per bit
// - burst flag tied to sync, only on the listed line ranges per standard
// - composite sync output is active low during sync
// - active-low reset is asynchronous and reinitialises everything
// - reference square input only used in genlock mode
// - burst lasts 9 subcarrier cycles, or 10 only when gcr[1:0] is 1
// - subcarrier synthesis from a programmable 24-bit frequency word
// - two chroma bandwidths, wide and narrow
// - master mode turns port bits 0-4 into vs, hs and field outputs
// - bandwidth bit high selects wide filter; narrow after reset
`timescale 1ns/1ps
`include "cve_regs.svh"

// ----------------------------------------------------------------
// pixel fifo
// ----------------------------------------------------------------
module cve_fifo #(
	parameter int W     = 24,
	parameter int DEPTH = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0]  mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_r[i] <= '0;
		end
		else
		begin
			if (push)
			begin
				mem_r[wp_r] <= in_data;
				wp_r        <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
			end
			if (pop)
				rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : cve_fifo

// ----------------------------------------------------------------
// encoder core
// ----------------------------------------------------------------
module cve_core #(
	parameter logic [7:0] ID2_VAL = 8'h5a,
	parameter logic [7:0] ID1_VAL = 8'h3c,
	parameter logic [7:0] ID0_VAL = 8'h01,
	parameter logic [7:0] REV_VAL = 8'h01
) (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic       pixel_clock_27m,
	input  wire logic [7:0] pixel_data_in,
	input  wire logic       genlock_ref_square,
	input  wire logic       slave_addr_sel_lo,
	input  wire logic       slave_addr_sel_hi,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic [7:0] gp_port_in,
	output logic      [7:0] gp_port_out,
	output logic      [7:0] gp_port_oe,
	output logic            composite_sync_n,
	output logic            burst_flag,
	output logic            hsync_out,
	output logic            vsync_out,
	output logic      [7:0] luma_dac,
	output logic      [7:0] chroma_dac,
	output logic      [7:0] comp_dac,
	output logic            pixel_fifo_ready
);
	// id values above are arbitrary
	cve_pkg::cve_state_s st_r;
	cve_pkg::cve_state_s st_nxt;
	cve_pkg::cve_pix_s   fin_data;
	cve_pkg::cve_pix_s   fout_data;
	logic                rst_s1_r;
	logic                rst_n_r;
	logic                push_c;
	logic                pop_c;
	logic                fin_ready;
	logic                fout_valid;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	cve_fifo #(.W(24), .DEPTH(8)) u_fifo (
		.clk       (core_clk),
		.rst_n     (rst_n_r),
		.in_valid  (push_c),
		.in_ready  (fin_ready),
		.in_data   (fin_data),
		.out_valid (fout_valid),
		.out_ready (pop_c),
		.out_data  (fout_data)
	);

	function automatic logic [7:0] rd_reg(input cve_pkg::cve_state_s s, input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		if (a == `CVE_OFF_ID2) d = ID2_VAL;
		else if (a == `CVE_OFF_ID1) d = ID1_VAL;
		else if (a == `CVE_OFF_ID0) d = ID0_VAL;
		else if (a == `CVE_OFF_REV) d = REV_VAL;
		else if (a == `CVE_OFF_GCR) d = s.gcr;
		else if (a == `CVE_OFF_VOCR) d = s.vocr;
		else if (a == `CVE_OFF_FREQ2) d = s.freq[23:16];
		else if (a == `CVE_OFF_FREQ1) d = s.freq[15:8];
		else if (a == `CVE_OFF_FREQ0) d = s.freq[7:0];
		else if (a == `CVE_OFF_GPPRD) d = s.gp_s2 & s.gppctl;
		else if (a == `CVE_OFF_GPSCTL) d = s.gpsctl;
		return d;
	endfunction : rd_reg

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic       start, stop, srise, sfall, tick, is625, is_code, blines, act, wide;
		logic [10:0] htot, blen;
		logic [9:0]  ltot, f2;
		logic [7:0]  pb, cb, cr;
		logic [9:0]  csum;
		st_nxt = st_r;
		push_c = 1'b0;
		pop_c  = 1'b0;
		fin_data = '0;
		csum     = 10'h000;
		// input synchronisers
		st_nxt.scl_s1 = scl_in;
		st_nxt.scl_s2 = st_r.scl_s1;
		st_nxt.scl_q  = st_r.scl_s2;
		st_nxt.sda_s1 = sda_in;
		st_nxt.sda_s2 = st_r.sda_s1;
		st_nxt.sda_q  = st_r.sda_s2;
		st_nxt.pck_s1 = pixel_clock_27m;
		st_nxt.pck_s2 = st_r.pck_s1;
		st_nxt.pck_q  = st_r.pck_s2;
		st_nxt.ref_s1 = genlock_ref_square;
		st_nxt.ref_s2 = st_r.ref_s1;
		st_nxt.ref_q  = st_r.ref_s2;
		st_nxt.sa_s1  = {slave_addr_sel_hi, slave_addr_sel_lo};
		st_nxt.sa_s2  = st_r.sa_s1;
		st_nxt.pd_s1  = pixel_data_in;
		st_nxt.pd_s2  = st_r.pd_s1;
		st_nxt.gp_s1  = gp_port_in;
		st_nxt.gp_s2  = st_r.gp_s1;
		start = st_r.scl_s2 & st_r.sda_q & ~st_r.sda_s2;
		stop  = st_r.scl_s2 & ~st_r.sda_q & st_r.sda_s2;
		srise = st_r.scl_s2 & ~st_r.scl_q;
		sfall = ~st_r.scl_s2 & st_r.scl_q;

		// ----------------------------------------------------------------
		// i2c register port
		// ----------------------------------------------------------------
		if (start)
		begin
			st_nxt.ist    = cve_pkg::I2C_ADDR;
			st_nxt.bitc   = 4'h0;
			st_nxt.sda_oe = 1'b0;
		end
		else if (stop)
		begin
			st_nxt.ist    = cve_pkg::I2C_IDLE;
			st_nxt.sda_oe = 1'b0;
		end
		else
		begin
			case (st_r.ist)
				cve_pkg::I2C_ADDR, cve_pkg::I2C_WRB:
				begin
					if (srise)
					begin
						st_nxt.sh   = {st_r.sh[6:0], st_r.sda_s2};
						st_nxt.bitc = st_r.bitc + 4'h1;
					end
					else if (sfall && st_r.bitc == 4'h8)
					begin
						st_nxt.bitc = 4'h0;
						if (st_r.ist == cve_pkg::I2C_ADDR)
						begin
							if (st_r.sh[7:1] == {`CVE_I2C_ADDR_HI, st_r.sa_s2})
							begin
								st_nxt.ist    = cve_pkg::I2C_AACK;
								st_nxt.rw     = st_r.sh[0];
								st_nxt.first  = 1'b1;
								st_nxt.sda_oe = 1'b1;
							end
							else
								st_nxt.ist = cve_pkg::I2C_IDLE;
						end
						else
						begin
							st_nxt.ist    = cve_pkg::I2C_WACK;
							st_nxt.sda_oe = 1'b1;
							st_nxt.first  = 1'b0;
							if (st_r.first)
								st_nxt.ptr = st_r.sh;
							else
							begin
								st_nxt.ptr = st_r.ptr + 8'h01;
								if (st_r.ptr == `CVE_OFF_GCR) st_nxt.gcr = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_VOCR) st_nxt.vocr = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_FREQ2) st_nxt.freq[23:16] = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_FREQ1) st_nxt.freq[15:8] = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_FREQ0) st_nxt.freq[7:0] = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_GPPCTL) st_nxt.gppctl = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_GPPWR) st_nxt.gppwr = st_r.sh;
								else if (st_r.ptr == `CVE_OFF_GPSCTL) st_nxt.gpsctl = st_r.sh;
							end
						end
					end
				end
				cve_pkg::I2C_AACK, cve_pkg::I2C_WACK, cve_pkg::I2C_RACK:
				begin
					if (srise && st_r.ist == cve_pkg::I2C_RACK)
					begin
						st_nxt.ack_ok = ~st_r.sda_s2;
						if (st_r.sda_s2)
							st_nxt.ist = cve_pkg::I2C_IDLE;
						else
							st_nxt.ptr = st_r.ptr + 8'h01;
					end
					else if (sfall)
					begin
						st_nxt.sda_oe = 1'b0;
						st_nxt.bitc   = 4'h0;
						if (st_r.ist == cve_pkg::I2C_WACK || !st_r.rw)
							st_nxt.ist = cve_pkg::I2C_WRB;
						else if (st_r.ist == cve_pkg::I2C_AACK || st_r.ack_ok)
						begin
							st_nxt.ist    = cve_pkg::I2C_RDB;
							st_nxt.sh     = rd_reg(st_r, st_r.ptr);
							st_nxt.sda_oe = ~st_nxt.sh[7];
						end
					end
				end
				cve_pkg::I2C_RDB:
				begin
					if (sfall)
					begin
						if (st_r.bitc == 4'h7)
						begin
							st_nxt.ist    = cve_pkg::I2C_RACK;
							st_nxt.sda_oe = 1'b0;
							st_nxt.ack_ok = 1'b0;
						end
						else
						begin
							st_nxt.sh     = {st_r.sh[6:0], 1'b0};
							st_nxt.sda_oe = ~st_r.sh[6];
							st_nxt.bitc   = st_r.bitc + 4'h1;
						end
					end
				end
				default: st_nxt.ist = cve_pkg::I2C_IDLE;
			endcase
		end

		// ----------------------------------------------------------------
		// standard and timing
		// ----------------------------------------------------------------
		tick  = st_r.pck_s2 & ~st_r.pck_q;
		is625 = st_r.gcr[0];
		htot  = is625 ? `CVE_HTOT_625 : `CVE_HTOT_525;
		ltot  = is625 ? `CVE_LINES_625 : `CVE_LINES_525;
		f2    = is625 ? `CVE_F2_625 : `CVE_F2_525;
		blen  = (st_r.gcr[1:0] == 2'h1) ? `CVE_BST_10CYC : `CVE_BST_9CYC;
		blines = is625 ?
			((st_r.line >= `CVE_BL_625_A && st_r.line <= `CVE_BL_625_B) ||
			 (st_r.line >= `CVE_BL_625_C && st_r.line <= `CVE_BL_625_D)) :
			((st_r.line >= `CVE_BL_525_A && st_r.line <= `CVE_BL_525_B) ||
			 (st_r.line >= `CVE_BL_525_C && st_r.line <= `CVE_BL_525_D));
		act   = blines && st_r.hcnt >= `CVE_ACT_ST && st_r.hcnt < `CVE_ACT_END;
		wide  = st_r.vocr[`CVE_BIT_CHROMA_WIDE_BAND_SEL];
		pb    = st_r.pd_s2;
		is_code = st_r.b3 == 8'hff && st_r.b2 == 8'h00 && st_r.b1 == 8'h00;
		cb = wide ? fout_data.cb : 8'((9'(fout_data.cb) + 9'(st_r.cb_p)) >> 1);
		cr = wide ? fout_data.cr : 8'((9'(fout_data.cr) + 9'(st_r.cr_p)) >> 1);
		st_nxt.fifo_rdy = fin_ready;

		if (tick)
		begin
			st_nxt.half = ~st_r.half;
			st_nxt.b1 = pb;
			st_nxt.b2 = st_r.b1;
			st_nxt.b3 = st_r.b2;
			st_nxt.dph = st_r.dph + 2'h1;
			st_nxt.acc = st_r.acc + st_r.freq;
			if (st_r.gpsctl[`CVE_BIT_GENLKEN] && st_r.ref_s2 && !st_r.ref_q)
				st_nxt.acc = 24'h000000;
			// horizontal and line counters run free in master mode; slave mode resets them on timing codes
			if (st_r.hcnt >= htot - 11'h001)
			begin
				st_nxt.hcnt = 11'h000;
				st_nxt.line = (st_r.line >= ltot) ? 10'h001 : st_r.line + 10'h001;
				if (st_r.line >= ltot || st_r.line == f2)
					st_nxt.fld = st_r.fld + 3'h1;
			end
			else
				st_nxt.hcnt = st_r.hcnt + 11'h001;
			if (is_code)
			begin
				st_nxt.dph = 2'h0;
				if (!st_r.gpsctl[`CVE_BIT_TIMING_SOURCE_SELECT])
				begin
					st_nxt.f_l = pb[6];
					st_nxt.h_l = pb[4];
					if (pb[4] && !st_r.h_l)
						st_nxt.hcnt = 11'h000;
					if (st_r.f_l && !pb[6])
						st_nxt.line = 10'h001;
				end
			end
			else if (st_r.gpsctl[`CVE_BIT_TIMING_SOURCE_SELECT] || (pb != 8'hff && pb != 8'h00))
			begin
				case (st_r.dph)
					2'h0, 2'h2: st_nxt.y_l = pb;
					2'h1: st_nxt.cr_l = pb;
					default: st_nxt.cb_l = pb;
				endcase
				if (st_r.dph == 2'h1 || st_r.dph == 2'h3)
				begin
					push_c = 1'b1;
					fin_data.y  = st_r.y_l;
					fin_data.cb = (st_r.dph == 2'h3) ? pb : st_r.cb_l;
					fin_data.cr = (st_r.dph == 2'h1) ? pb : st_r.cr_l;
				end
			end

			// ----------------------------------------------------------------
			// sync, burst and sample output
			// ----------------------------------------------------------------
			st_nxt.hs = st_r.hcnt < `CVE_SYNC_W;
			st_nxt.vs = (st_r.line <= `CVE_VS_N) ||
				(st_r.line > f2 && st_r.line <= f2 + `CVE_VS_N);
			st_nxt.csync_n = ~(st_nxt.hs | st_nxt.vs);
			st_nxt.burst = blines && st_r.hcnt >= `CVE_BST_ST &&
				st_r.hcnt < `CVE_BST_ST + blen;
			if (st_nxt.hs || st_nxt.vs)
			begin
				st_nxt.luma   = 8'h00;
				st_nxt.chroma = 8'h80;
			end
			else if (st_nxt.burst)
			begin
				st_nxt.luma   = 8'h10;
				st_nxt.chroma = st_r.acc[23] ? 8'ha0 : 8'h60;
			end
			else if (!act)
			begin
				st_nxt.luma   = 8'h10;
				st_nxt.chroma = 8'h80;
			end
			else if (st_r.half && fout_valid)
			begin
				pop_c = 1'b1;
				st_nxt.luma = fout_data.y;
				st_nxt.cb_p = fout_data.cb;
				st_nxt.cr_p = fout_data.cr;
				case (st_r.acc[23:22])
					2'h0: st_nxt.chroma = cb;
					2'h1: st_nxt.chroma = cr;
					2'h2: st_nxt.chroma = ~cb;
					default: st_nxt.chroma = ~cr;
				endcase
			end
			csum = 10'(st_nxt.luma) + 10'(st_nxt.chroma) - 10'h080;
			st_nxt.comp = csum[9] ? 8'h00 : (csum[8] ? 8'hff : csum[7:0]);
		end

		// ----------------------------------------------------------------
		// general purpose port
		// ----------------------------------------------------------------
		for (int i = 0; i < 8; i++)
		begin
			st_nxt.gpo[i]  = st_r.gppwr[i];
			st_nxt.gpoe[i] = ~st_r.gppctl[i];
		end
		if (st_r.gpsctl[`CVE_BIT_TIMING_SOURCE_SELECT])
		begin
			st_nxt.gpo[4:0]  = {st_r.fld, st_r.hs, st_r.vs};
			st_nxt.gpoe[4:0] = 5'h1f;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			st_r        <= '0;
			st_r.ist    <= cve_pkg::I2C_IDLE;
			st_r.scl_s1 <= 1'b1;
			st_r.scl_s2 <= 1'b1;
			st_r.scl_q  <= 1'b1;
			st_r.sda_s1 <= 1'b1;
			st_r.sda_s2 <= 1'b1;
			st_r.sda_q  <= 1'b1;
			st_r.gcr    <= `CVE_RST_GCR;
			st_r.vocr   <= `CVE_RST_VOCR;
			st_r.freq   <= `CVE_RST_FREQ;
			st_r.gppctl <= `CVE_RST_GPPCTL;
			st_r.gppwr  <= `CVE_RST_GPPWR;
			st_r.gpsctl <= `CVE_RST_GPSCTL;
			st_r.line   <= 10'h001;
			st_r.csync_n <= 1'b1;
			st_r.luma   <= 8'h10;
			st_r.chroma <= 8'h80;
			st_r.comp   <= 8'h10;
		end
		else
			st_r <= st_nxt;
	end

	assign sda_out          = 1'b0;
	assign sda_oe           = st_r.sda_oe;
	assign gp_port_out      = st_r.gpo;
	assign gp_port_oe       = st_r.gpoe;
	assign composite_sync_n = st_r.csync_n;
	assign burst_flag       = st_r.burst;
	assign hsync_out        = st_r.hs;
	assign vsync_out        = st_r.vs;
	assign luma_dac         = st_r.luma;
	assign chroma_dac       = st_r.chroma;
	assign comp_dac         = st_r.comp;
	assign pixel_fifo_ready = st_r.fifo_rdy;
endmodule : cve_core

// ### sim/cve_core_props.sv
// Purpose: port checks of the encoder core
// Assumes: pixel clock period of at least four core_clk
// Notes:   bound from tb_top
`timescale 1ns/1ps
// ------------------------------------------------
// port checker
// ------------------------------------------------
module cve_core_props (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic       scl_in,
	input wire logic       sda_oe,
	input wire logic [7:0] gp_port_oe,
	input wire logic       composite_sync_n,
	input wire logic       burst_flag,
	input wire logic       hsync_out,
	input wire logic       vsync_out,
	input wire logic [7:0] luma_dac,
	input wire logic       pixel_fifo_ready
);
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	chk_csync_from_hv: assert property (composite_sync_n == !(hsync_out || vsync_out))
		else $error("composite sync differs from hsync or vsync");
	chk_burst_no_sync: assert property (burst_flag |-> composite_sync_n)
		else $error("burst flag inside sync");
	chk_burst_min_len: assert property ($rose(burst_flag) |=> burst_flag [*8])
		else $error("burst flag too short");
	chk_rst_out_vals: assert property ($rose(resetn) |->
		composite_sync_n && !burst_flag && !hsync_out && !vsync_out && luma_dac == 8'h10)
		else $error("outputs not at reset values");
	chk_rst_port_off: assert property ($rose(resetn) |->
		gp_port_oe == 8'h00 && !sda_oe && !pixel_fifo_ready)
		else $error("port or sda driven in reset");
	chk_dac_tick_hold: assert property ($changed(luma_dac) |=> $stable(luma_dac) [*2])
		else $error("luma dac changes faster than the tick");
	chk_hsync_min_width: assert property ($rose(hsync_out) |=> hsync_out [*8])
		else $error("hsync pulse too short");
	chk_ack_after_fall: assert property ($rose(sda_oe) |-> !scl_in && !$past(scl_in, 2))
		else $error("sda driven while scl high");
	cover property ($rose(burst_flag));
	cover property ($rose(vsync_out));
	cover property ($rose(sda_oe));
endmodule : cve_core_props

// ### sim/cve_vid_src.sv
// Purpose: host video source feeding 4:2:2 bytes with timing codes
// Assumes: pixel clock slowed to 5 MHz for the 20 MHz core
// Notes:   field bit high on every eighth line
`timescale 1ns/1ps
// ------------------------------------------------
// video source
// ------------------------------------------------
module cve_vid_src (
	output logic       pck,
	output logic [7:0] pd
);
	int         n = 0;
	logic [2:0] ln = 3'h0;
	logic [7:0] xy;
	initial
	begin
		pck = 1'b0;
		pd = 8'h00;
	end
	always #100 pck = ~pck;
	assign xy = {1'b1, &ln, 1'b0, n < 4, 4'h0};
	always @(negedge pck)
	begin
		if (n < 8)
			pd <= (n[1:0] == 2'h3) ? xy : ((n[1:0] == 2'h0) ? 8'hff : 8'h00);
		else
			pd <= n[0] ? (n[1] ? 8'h30 : 8'hc0) : 8'h10 + {1'b0, n[6:0]};
		n <= (n == 1727) ? 0 : n + 1;
		ln <= ln + {2'h0, n == 1727};
	end
endmodule : cve_vid_src

// ### sim/tb_top.sv
// Purpose: register and timing tests of the encoder core
// Assumes: i2c half bit of ten core_clk
// Notes:   sda and port pins resolved here
`timescale 1ns/1ps
// ------------------------------------------------
// testbench
// ------------------------------------------------
module tb_top;
	logic       core_clk = 1'b0;
	logic       resetn = 1'b0;
	logic       scl = 1'b1;
	logic       m_low = 1'b0;
	logic       pck;
	logic [7:0] pd;
	logic       sda_oe;
	logic [7:0] gp_out;
	logic [7:0] gp_oe;
	logic       csync_n;
	logic       burst;
	logic       hs;
	logic       vs;
	logic [7:0] luma;
	logic [7:0] chroma;
	logic [7:0] comp;
	logic       frdy;
	logic [7:0] v0;
	logic [7:0] v1;
	logic [7:0] qj;
	logic       k;
	int         miscompares = 0;
	int         n_checks = 0;
	always #25 core_clk = ~core_clk;
	cve_vid_src src_u (.pck(pck), .pd(pd));
	cve_core dut_u (
		.core_clk(core_clk), .resetn(resetn), .pixel_clock_27m(pck),
		.pixel_data_in(pd), .genlock_ref_square(1'b0),
		.slave_addr_sel_lo(1'b0), .slave_addr_sel_hi(1'b0),
		.scl_in(scl), .sda_in(!(m_low || sda_oe)), .sda_out(), .sda_oe(sda_oe),
		.gp_port_in((gp_oe & gp_out) | (~gp_oe & 8'h3c)), .gp_port_out(gp_out),
		.gp_port_oe(gp_oe), .composite_sync_n(csync_n), .burst_flag(burst),
		.hsync_out(hs), .vsync_out(vs), .luma_dac(luma), .chroma_dac(chroma),
		.comp_dac(comp), .pixel_fifo_ready(frdy)
	);
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report
	task cmp(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task hb;
		repeat (10) @(posedge core_clk);
		#1;
	endtask : hb
	task bit_x(input logic b, output logic r);
		m_low = !b;
		hb;
		scl = 1'b1;
		hb;
		r = !(m_low || sda_oe);
		scl = 1'b0;
		hb;
	endtask : bit_x
	task sta;
		m_low = 1'b0;
		hb;
		scl = 1'b1;
		hb;
		m_low = 1'b1;
		hb;
		scl = 1'b0;
		hb;
	endtask : sta
	task sto;
		m_low = 1'b1;
		hb;
		scl = 1'b1;
		hb;
		m_low = 1'b0;
		hb;
	endtask : sto
	task xb(input logic [7:0] d, input logic a, output logic [7:0] q, output logic ak);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], q[i]);
		bit_x(a, ak);
	endtask : xb
	task wr(input logic [7:0] p, input logic [7:0] v);
		sta;
		xb(8'h18, 1'b1, qj, k);
		cmp({7'h00, k}, 8'h00);
		xb(p, 1'b1, qj, k);
		xb(v, 1'b1, qj, k);
		sto;
	endtask : wr
	task rdc(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1);
		sta;
		xb(8'h18, 1'b1, qj, k);
		xb(p, 1'b1, qj, k);
		sta;
		xb(8'h19, 1'b1, qj, k);
		xb(8'hff, 1'b0, v0, k);
		xb(8'hff, 1'b1, v1, k);
		sto;
		cmp(v0, e0);
		cmp(v1 & ((p == 8'h20) ? 8'hf0 : 8'hff), e1);
	endtask : rdc
	task wait_on(input int sel);
		int n;
		n = 0;
		while (((sel == 0) ? vs : burst) !== 1'b1 && n < 60000)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		if (n >= 60000)
		begin
			miscompares++;
			$display("wrong value at %0t: wait ran out", $time);
			final_report;
		end
	endtask : wait_on
	initial
	begin
		repeat (10) @(posedge core_clk);
		#1;
		cmp({7'h00, csync_n}, 8'h01);
		cmp(gp_oe, 8'h00);
		cmp({7'h00, frdy}, 8'h00);
		resetn = 1'b1;
		hb;
		cmp({7'h00, frdy}, 8'h01);
		rdc(8'h00, 8'h5a, 8'h3c);
		rdc(8'h02, 8'h01, 8'h01);
		rdc(8'h05, 8'h00, 8'h00);
		rdc(8'h09, 8'h87, 8'hc1);
		rdc(8'h0b, 8'hf1, 8'h00);
		rdc(8'h30, 8'h00, 8'h00);
		wr(8'h05, 8'h20);
		rdc(8'h05, 8'h20, 8'h00);
		wr(8'h03, 8'h77);
		rdc(8'h03, 8'h01, 8'h00);
		sta;
		xb(8'h1a, 1'b1, qj, k);
		cmp({7'h00, k}, 8'h01);
		sto;
		wr(8'h04, 8'h01);
		wr(8'h20, 8'hf0);
		wr(8'h22, 8'ha5);
		cmp(gp_oe, 8'h0f);
		cmp(gp_out & 8'h0f, 8'h05);
		rdc(8'h20, 8'h00, 8'h30);
		wait_on(0);
		repeat (2) @(posedge core_clk);
		#1;
		cmp({6'h00, csync_n, vs}, 8'h01);
		cmp(luma, 8'h00);
		cmp(chroma, 8'h80);
		cmp(comp, 8'h00);
		wait_on(1);
		cmp({6'h00, csync_n, hs}, 8'h02);
		cmp(luma, 8'h10);
		wr(8'hff, 8'h01);
		cmp(gp_oe, 8'h1f);
		v0 = {6'h00, hs, vs};
		@(posedge core_clk);
		#1;
		cmp({6'h00, gp_out[1:0]}, v0);
		final_report;
	end
endmodule : tb_top

bind cve_core cve_core_props chk_u (
	.core_clk(core_clk), .resetn(resetn), .scl_in(scl_in), .sda_oe(sda_oe),
	.gp_port_oe(gp_port_oe), .composite_sync_n(composite_sync_n), .burst_flag(burst_flag),
	.hsync_out(hsync_out), .vsync_out(vsync_out), .luma_dac(luma_dac),
	.pixel_fifo_ready(pixel_fifo_ready)
);
